// ---- sbc_consts.svh ----
// Register offsets, field positions, reset values and timing constants
// of the static bank configuration and decode block.
// Assumes inclusion by bare name from the package and the modules.
`ifndef SBC_CONSTS_SVH
`define SBC_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SBC_OFS_CFG_BASE 8'h00
`define SBC_OFS_WIN_BASE 8'h10
`define SBC_OFS_STATUS 8'h20

// ****************************************
// Timing configuration fields
// ****************************************
`define SBC_CFG_HOLD_LSB 12
`define SBC_CFG_SETUP_LSB 8
`define SBC_CFG_BW_LSB 6
`define SBC_CFG_BCM_BIT 3
`define SBC_CFG_BL_LSB 1
`define SBC_CFG_SMT_BIT 0
`define SBC_CFG_WMASK 32'h000077CF
`define SBC_CFG_RESET 32'h00007700

// ****************************************
// Address window fields
// ****************************************
`define SBC_WIN_BASE_LSB 8
`define SBC_WIN_MASK_LSB 0
`define SBC_WIN_WMASK 32'h0000FFFF
`define SBC_WIN1_RESET 16'h18FC
`define SBC_WIN2_RESET 16'h14FC
`define SBC_WIN3_RESET 16'h0CFC
`define SBC_WIN4_RESET 16'h08FC
`define SBC_BANK0_BASE 8'h00
`define SBC_BANK0_MASK 8'hFC

// ****************************************
// Clock
// ****************************************
`define SBC_CLK_PERIOD_NS 40

`endif

// ---- sbc_pkg.sv ----
// Types shared by the static bank configuration and decode block.
// Assumes the constants header sits in the same folder.
`include "sbc_consts.svh"

package sbc_pkg;

	typedef enum logic [3:0] {
		SBC_IDLE = 4'h1,
		SBC_SETUP = 4'h2,
		SBC_STROBE = 4'h4,
		SBC_HOLD = 4'h8
	} sbc_state_e;

	typedef logic [7:0] sbc_byte_t;

endpackage

// ---- sbc_window_match.sv ----
// Matches the upper address byte against four bank windows and bank 0.
// Assumes windows come from the register file on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"

module sbc_window_match
	import sbc_pkg::*;
#(
	parameter int NBANK = 4
) (
	input wire logic [7:0] addr_hi, // Physical address bits 31:24
	input wire logic [NBANK*16-1:0] windows, // Base and mask per bank
	output logic [NBANK:0] hit, // One-hot bank match, bank 0 in bit 0
	output logic any_hit // A bank 1 to 4 window matched
);

	logic [NBANK:1] raw;
	logic [NBANK:1] lower_hit;

	genvar g;
	generate
		for (g = 1; g <= NBANK; g++) begin : g_win
			wire sbc_byte_t base = windows[(g-1)*16+`SBC_WIN_BASE_LSB +: 8];
			wire sbc_byte_t mask = windows[(g-1)*16+`SBC_WIN_MASK_LSB +: 8];
			assign raw[g] = (addr_hi & mask) == base; // [R10]
			if (g == 1) begin : g_first
				assign lower_hit[g] = 1'b0;
			end else begin : g_rest
				assign lower_hit[g] = lower_hit[g-1] | raw[g-1];
			end
			// Lowest matching bank wins on overlap
			assign hit[g] = raw[g] & ~lower_hit[g];
		end
	endgenerate

	assign any_hit = |raw;
	// Boot region stays fixed at zero
	assign hit[0] = ~any_hit && ((addr_hi & `SBC_BANK0_MASK) == `SBC_BANK0_BASE); // [R12]

endmodule
`default_nettype wire

// ---- sbc_cfg_decode.sv ----
// Decodes one bank timing configuration word into access parameters.
// Assumes a word that already has reserved bits cleared.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"

module sbc_cfg_decode
	import sbc_pkg::*;
(
	input wire logic [31:0] cfg, // Timing configuration word
	output logic [2:0] setup_wait, // Cycles from address to strobe
	output logic [2:0] hold_wait, // Cycles from strobe end to release
	output logic [5:0] beats, // Strobe beats per read
	output logic [2:0] step, // Address step per beat in bytes
	output logic byte_ctl, // Byte strobes also on reads
	output logic burst_rom // Burst ROM selected
);

	wire [1:0] bw = cfg[`SBC_CFG_BW_LSB +: 2];
	wire [1:0] bl = cfg[`SBC_CFG_BL_LSB +: 2];

	assign setup_wait = cfg[`SBC_CFG_SETUP_LSB +: 3]; // [R01]
	assign hold_wait = cfg[`SBC_CFG_HOLD_LSB +: 3]; // [R02]
	assign burst_rom = cfg[`SBC_CFG_SMT_BIT]; // [R09]
	// Byte control only counts for normal memory
	assign byte_ctl = cfg[`SBC_CFG_BCM_BIT] & ~burst_rom; // [R05]
	// Burst of 4, 8, 16 or 32 beats; a single beat otherwise
	assign beats = burst_rom ? (6'h04 << bl) : 6'h01; // [R06]
	// Reserved width code falls back to 8 bits
	assign step = (bw == 2'h1) ? 3'h2 : (bw == 2'h2) ? 3'h4 : 3'h1; // [R04]

endmodule
`default_nettype wire

// ---- sbc_top.sv ----
// Static memory bank configuration, address decode and access timing.
// Assumes an APB master on pclk and a system requester on the same clock.
//
// Notes on behaviour
// R01 - Setup field 10:8 waits 0 to 7 cycles from address to strobe; resets 111.
// R02 - Hold field 14:12 waits that many cycles after strobe before release.
// R03 - Configuration bits 11 and 5:4 ignore writes and read zero.
// R04 - Width field 7:6 picks 8, 16 or 32 bits; 11 is reserved.
// R05 - Bit 3 selects byte control SRAM, honoured only for normal memory.
// R06 - Burst ROM length field 2:1 gives 4, 8, 16 or 32 beats.
// R07 - Software must not pair 16 beats with a 32-bit bus.
// R08 - Software uses 32 beats only with an 8-bit bus.
// R09 - Bit 0 selects normal memory or burst ROM; resets to normal.
// R10 - Bank n is active when address byte masked equals its base.
// R11 - Software keeps bank windows apart; overlaps are unpredictable.
// R12 - Bank 0 always decodes at base zero as boot region; the code selects it only if no bank 1 to 4 window matches.
// R13 - Window base field 15:8 resets to 18, 14, 0C, 08.
// R14 - Window mask field resets to FC for all four banks.
// R15 - Window bits 31:16 read zero; fields return to defaults on reset.
// R16 - Bank select asserts in the same cycle as the address.
// R17 - No window match means no bank 1 to 4 select.
// R18 - All wait cycles are counted in controller clock periods.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_consts.svh"

module sbc_top
	import sbc_pkg::*;
#(
	parameter int NBANK = 4
) (
	input wire logic pclk, // System clock, 25 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB write
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic sys_req, // Access request, held until done
	input wire logic sys_write, // Access is a write
	input wire logic [31:0] sys_addr, // Physical address
	input wire logic [3:0] sys_be, // Byte enables
	output logic sys_done, // Access finished, one cycle
	output logic [31:0] mem_addr, // External address
	output logic [NBANK:0] bank_select_n, // Bank chip selects, active low
	output logic rd_n, // Read strobe, active low
	output logic we_n, // Write strobe, active low
	output logic [3:0] byte_sel_n // Byte strobes, active low
);

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] cfg_q [NBANK];
	logic [15:0] win_q [NBANK];
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	wire apb_setup = psel && !penable;
	wire apb_done = psel && penable && pready_q;
	wire apb_wr = apb_done && pwrite && mapped;
	wire [5:0] word_idx = paddr[7:2];
	wire cfg_sel = (paddr >= `SBC_OFS_CFG_BASE) && (paddr < `SBC_OFS_WIN_BASE);
	wire win_sel = (paddr >= `SBC_OFS_WIN_BASE) && (paddr < `SBC_OFS_STATUS);
	wire sts_sel = paddr == `SBC_OFS_STATUS;
	wire [1:0] reg_idx = word_idx[1:0];
	wire mapped = (paddr[1:0] == 2'h0) && (cfg_sel || win_sel || sts_sel);
	localparam logic [15:0] WIN_RST [NBANK] = '{`SBC_WIN1_RESET, `SBC_WIN2_RESET, `SBC_WIN3_RESET, `SBC_WIN4_RESET};
	logic [NBANK*16-1:0] win_flat;
	logic [31:0] sts_word;
	logic [31:0] rd_word;

	genvar g;
	generate
		for (g = 0; g < NBANK; g++) begin : g_regs
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_q[g] <= `SBC_CFG_RESET; // [R01]
					win_q[g] <= WIN_RST[g]; // [R13] [R14] [R15]
				end else if (apb_wr && reg_idx == 2'(g)) begin
					if (cfg_sel) begin
						cfg_q[g] <= pwdata & `SBC_CFG_WMASK; // [R03]
					end
					if (win_sel) begin
						win_q[g] <= pwdata[15:0]; // [R15]
					end
				end
			end
			assign win_flat[g*16 +: 16] = win_q[g];
		end
	endgenerate

	assign rd_word = cfg_sel ? cfg_q[reg_idx] :
		win_sel ? {16'h0000, win_q[reg_idx]} : // [R15]
		sts_sel ? sts_word : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_setup;
			pslverr_q <= apb_setup && !mapped;
			if (apb_setup) begin
				prdata_q <= mapped ? rd_word : 32'h00000000;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ****************************************
	// Bank decode and selected configuration
	// ****************************************
	logic [NBANK:0] hit;
	logic any_hit;

	sbc_window_match #(.NBANK(NBANK)) u_match (
		.addr_hi(sys_addr[31:24]),
		.windows(win_flat),
		.hit(hit),
		.any_hit(any_hit)
	);

	logic [31:0] sel_cfg;
	always_comb begin
		sel_cfg = `SBC_CFG_RESET;
		for (int i = 0; i < NBANK; i++) begin
			if (hit[i+1]) begin
				sel_cfg = cfg_q[i];
			end
		end
	end

	logic [2:0] setup_wait;
	logic [2:0] hold_wait;
	logic [5:0] beats;
	logic [2:0] step;
	logic byte_ctl;
	logic burst_rom;

	sbc_cfg_decode u_cfg (
		.cfg(sel_cfg),
		.setup_wait(setup_wait),
		.hold_wait(hold_wait),
		.beats(beats),
		.step(step),
		.byte_ctl(byte_ctl),
		.burst_rom(burst_rom)
	);

	// ****************************************
	// Access sequencer
	// ****************************************
	sbc_state_e state_q;
	sbc_state_e state_d;
	logic [2:0] cnt_q;
	logic [5:0] beat_q;
	logic [2:0] hold_q;
	logic [2:0] step_q;
	logic wr_q;
	logic bctl_q;
	logic [3:0] be_q;
	logic [31:0] addr_q;
	logic [NBANK:0] cs_n_q;
	logic rd_n_q;
	logic we_n_q;
	logic [3:0] bsel_n_q;
	logic done_q;
	logic miss_q;

	wire accept = (state_q == SBC_IDLE) && sys_req && !done_q;
	wire any_sel = |hit;
	wire setup_last = (state_q == SBC_SETUP) && (cnt_q == 3'h1);
	wire strobe_last = (state_q == SBC_STROBE) && (beat_q == 6'h01);
	wire hold_last = (state_q == SBC_HOLD) && (cnt_q == 3'h1);
	wire go_strobe = (accept && any_sel && setup_wait == 3'h0) || setup_last;
	wire release_now = (strobe_last && hold_q == 3'h0) || hold_last;
	wire [3:0] strobe_bytes = (wr_q || bctl_q) ? ~be_q : 4'hF; // [R05]

	always_comb begin
		state_d = state_q;
		case (state_q)
			SBC_IDLE: begin
				if (accept && any_sel) begin
					state_d = (setup_wait == 3'h0) ? SBC_STROBE : SBC_SETUP; // [R01]
				end
			end
			SBC_SETUP: begin
				if (setup_last) begin
					state_d = SBC_STROBE;
				end
			end
			SBC_STROBE: begin
				if (strobe_last) begin
					state_d = (hold_q == 3'h0) ? SBC_IDLE : SBC_HOLD; // [R02]
				end
			end
			SBC_HOLD: begin
				if (hold_last) begin
					state_d = SBC_IDLE;
				end
			end
			default: begin
				state_d = SBC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= SBC_IDLE;
			cnt_q <= 3'h0;
			beat_q <= 6'h00;
			hold_q <= 3'h0;
			step_q <= 3'h1;
			wr_q <= 1'b0;
			bctl_q <= 1'b0;
			be_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (accept) begin
				cnt_q <= setup_wait; // [R18]
				beat_q <= sys_write ? 6'h01 : beats; // [R06]
				hold_q <= hold_wait;
				step_q <= step; // [R04]
				wr_q <= sys_write;
				bctl_q <= byte_ctl;
				be_q <= sys_be;
			end else if (state_q == SBC_SETUP) begin
				cnt_q <= cnt_q - 3'h1; // [R18]
			end else if (state_q == SBC_STROBE) begin
				beat_q <= beat_q - 6'h01;
				cnt_q <= hold_q;
			end else if (state_q == SBC_HOLD) begin
				cnt_q <= cnt_q - 3'h1; // [R18]
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_q <= 32'h00000000;
			cs_n_q <= '1;
			rd_n_q <= 1'b1;
			we_n_q <= 1'b1;
			bsel_n_q <= 4'hF;
			done_q <= 1'b0;
			miss_q <= 1'b0;
		end else begin
			done_q <= release_now || (accept && !any_sel);
			if (accept) begin
				addr_q <= sys_addr;
				cs_n_q <= ~hit; // [R16] [R17]
				miss_q <= !any_sel;
			end else if (release_now) begin
				cs_n_q <= '1;
			end
			if (state_q == SBC_STROBE && !strobe_last) begin
				addr_q <= addr_q + {29'h0, step_q}; // [R06]
			end
			if (go_strobe) begin
				rd_n_q <= accept ? sys_write : wr_q;
				we_n_q <= accept ? !sys_write : !wr_q;
				bsel_n_q <= accept ? ((sys_write || byte_ctl) ? ~sys_be : 4'hF) : strobe_bytes;
			end else if (strobe_last) begin
				rd_n_q <= 1'b1;
				we_n_q <= 1'b1;
				bsel_n_q <= 4'hF;
			end
		end
	end

	assign sts_word = {16'h0000, 3'h0, miss_q, 3'h0, ~cs_n_q, state_q};
	assign sys_done = done_q;
	assign mem_addr = addr_q;
	assign bank_select_n = cs_n_q;
	assign rd_n = rd_n_q;
	assign we_n = we_n_q;
	assign byte_sel_n = bsel_n_q;

	// ****************************************
	// Assertions
	// ****************************************
	logic [3:0] gap_h;
	logic [3:0] exp_gap_h;
	logic [6:0] beat_h;
	logic [6:0] exp_beat_h;
	logic [3:0] hold_h;
	wire strobe_on = !rd_n_q || !we_n_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_h <= 4'h0;
			exp_gap_h <= 4'h0;
			beat_h <= 7'h00;
			exp_beat_h <= 7'h00;
			hold_h <= 4'h0;
		end else begin
			if (accept) begin
				gap_h <= 4'h0;
				exp_gap_h <= {1'b0, setup_wait};
				beat_h <= 7'h00;
				exp_beat_h <= sys_write ? 7'h01 : {1'b0, beats};
			end else if (state_q == SBC_SETUP) begin
				gap_h <= gap_h + 4'h1;
			end
			if (strobe_on) begin
				beat_h <= beat_h + 7'h01;
			end
			hold_h <= (strobe_on || &cs_n_q) ? 4'h0 : hold_h + 4'h1;
		end
	end

	sequence s_strobe_start;
		$fell(rd_n_q) || $fell(we_n_q);
	endsequence

	sequence s_strobe_end;
		$rose(rd_n_q) || $rose(we_n_q);
	endsequence

	a_setup_gap_count: assert property (@(posedge pclk) disable iff (!presetn) // [R01] [R18]
		s_strobe_start |-> gap_h == exp_gap_h)
		else $error("strobe not after programmed setup wait");
	a_hold_gap_count: assert property (@(posedge pclk) disable iff (!presetn) // [R02] [R18]
		$rose(|(~cs_n_q) == 1'b0) |-> hold_h == {1'b0, $past(hold_q)})
		else $error("bank released after wrong hold wait");
	a_burst_beat_count: assert property (@(posedge pclk) disable iff (!presetn) // [R06] [R09]
		s_strobe_end |-> beat_h == exp_beat_h)
		else $error("strobe beat count differs from burst length");
	a_cs_with_addr: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
		accept && any_sel |=> bank_select_n == ~$past(hit) && mem_addr == $past(sys_addr))
		else $error("select not driven with the address");
	a_no_match_no_cs: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
		accept && !any_hit |=> &bank_select_n[NBANK:1] ##1 &bank_select_n[NBANK:1])
		else $error("bank select asserted without window match");
	a_rsvd_cfg_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R03]
		pready_q && cfg_sel |-> prdata[11] == 1'b0 && prdata[5:4] == 2'h0)
		else $error("reserved configuration bits read nonzero");
	a_win_upper_zero: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		pready_q && win_sel |-> prdata[31:16] == 16'h0000)
		else $error("window upper bits read nonzero");
	a_byte_ctl_read: assert property (@(posedge pclk) disable iff (!presetn) // [R05]
		$fell(rd_n_q) && !bctl_q |-> byte_sel_n == 4'hF)
		else $error("byte strobes on read outside byte control mode");
	a_width_step: assert property (@(posedge pclk) disable iff (!presetn) // [R04]
		!rd_n_q && $past(!rd_n_q) && state_q == SBC_STROBE |-> mem_addr == $past(mem_addr) + {29'h0, step_q})
		else $error("burst address step does not match bus width");
	a_boot_bank: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		accept && !any_hit && sys_addr[31:26] == 6'h00 |=> !bank_select_n[0])
		else $error("boot bank not selected at base zero");

endmodule
`default_nettype wire

// ---- sbc_mem_model.sv ----
// External static memory model: watches selects, strobes and address.
// Assumes registered outputs of sbc_top on the same clock.
`timescale 1ns/1ps
`default_nettype none
module sbc_mem_model (
	input wire logic pclk, // System clock
	input wire logic [4:0] bank_select_n, // Chip selects, active low
	input wire logic rd_n, // Read strobe, active low
	input wire logic we_n, // Write strobe, active low
	input wire logic [31:0] mem_addr, // External address
	input wire logic [3:0] byte_sel_n // Byte strobes, active low
);
	// ****************************************
	// Access capture, one record per select
	// ****************************************
	int acc_n = 0;
	int bank, su, bt, hd;
	logic act = 1'b0;
	logic [31:0] a0, al;
	logic [3:0] bs;
	always @(negedge pclk) begin
		if (bank_select_n !== 5'h1F) begin
			if (!act) begin
				act = 1'b1;
				su = 0;
				bt = 0;
				hd = 0;
				a0 = mem_addr;
				for (int i = 0; i < 5; i++) if (bank_select_n[i] === 1'b0) bank = i;
			end
			if (rd_n === 1'b0 || we_n === 1'b0) begin
				bt++;
				al = mem_addr;
				bs = byte_sel_n;
			end else if (bt == 0) su++;
			else hd++;
		end else if (act) begin
			act = 1'b0;
			acc_n++;
		end
	end
endmodule
`default_nettype wire

// ---- static_bank_config_decode_tb.sv ----
// Self-checking bench: APB master, access requester and reference model.
// Assumes sbc_top and sbc_mem_model compiled beforehand.
`timescale 1ns/1ps
`default_nettype none
module static_bank_config_decode_tb;
	// ****************************************
	// Signals, design and memory model
	// ****************************************
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic sys_req = 1'b0, sys_write = 1'b0, pready, pslverr, sys_done, rd_n, we_n, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, sys_addr = 32'h0, seed = 32'hEF0E, prdata, rd, mem_addr;
	logic [3:0] sys_be = 4'hF, byte_sel_n;
	logic [4:0] bank_select_n;
	logic [31:0] cfg_m [4];
	logic [15:0] win_m [4];
	logic [7:0] hi [7] = '{8'h01, 8'h19, 8'h40, 8'h0D, 8'h0A, 8'hFF, 8'h14};
	int mismatches = 0, check_count = 0;
	sbc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sys_req(sys_req), .sys_write(sys_write), .sys_addr(sys_addr), .sys_be(sys_be),
		.sys_done(sys_done), .mem_addr(mem_addr), .bank_select_n(bank_select_n), .rd_n(rd_n),
		.we_n(we_n), .byte_sel_n(byte_sel_n));
	sbc_mem_model mdl (.pclk(pclk), .bank_select_n(bank_select_n), .rd_n(rd_n), .we_n(we_n),
		.mem_addr(mem_addr), .byte_sel_n(byte_sel_n));
	initial forever #20 pclk = ~pclk;
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task close_out;
		$display("counts: checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task fail(input string nm);
		mismatches++;
		$display("ERROR %s expected answer seen timeout", nm);
		close_out();
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) fail("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	// Reference decode and timing for one access
	task acc(input logic w, input logic [31:0] a, input logic [3:0] be);
		int b, i, bt, st, n;
		logic [31:0] c;
		b = -1;
		for (i = 4; i >= 1; i--) if ((a[31:24] & win_m[i-1][7:0]) == win_m[i-1][15:8]) b = i;
		if (b < 0 && (a[31:24] & 8'hFC) == 8'h00) b = 0;
		c = (b > 0) ? cfg_m[b-1] : 32'h7700;
		bt = (!w && c[0]) ? (4 << c[2:1]) : 1;
		st = (c[7:6] == 2'b01) ? 2 : (c[7:6] == 2'b10) ? 4 : 1;
		n = mdl.acc_n;
		@(posedge pclk);
		sys_req <= 1'b1;
		sys_write <= w;
		sys_addr <= a;
		sys_be <= be;
		for (i = 1; i < 80; i++) begin
			@(posedge pclk);
			if (sys_done === 1'b1) break;
		end
		if (i == 80) fail("sys_done");
		sys_req <= 1'b0;
		if (b < 0) begin
			chk("refused cycles", 0, i - 2);
			chk("accesses", n, mdl.acc_n);
		end else begin
			chk("cycles", c[10:8] + c[14:12] + bt, i - 2);
			chk("bank", b, mdl.bank);
			chk("setup", c[10:8], mdl.su);
			chk("hold", c[14:12], mdl.hd);
			chk("beats", bt, mdl.bt);
			chk("first addr", a, mdl.a0);
			chk("last addr", a + (bt - 1) * st, mdl.al);
			chk("byte sel", (w || (c[3] && !c[0])) ? 4'(~be) : 4'hF, mdl.bs);
		end
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int i;
		logic [31:0] c;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 4; i++) cfg_m[i] = 32'h7700;
		win_m = '{16'h18FC, 16'h14FC, 16'h0CFC, 16'h08FC};
		for (i = 0; i < 4; i++) begin
			rdc("cfg reset", 8'(4 * i), 32'h7700);
			rdc("window reset", 8'(16 + 4 * i), {16'h0, win_m[i]});
		end
		$display("test reset values done");
		apb(1'b1, 8'h04, 32'hFFFFFFFF);
		rdc("cfg reserved", 8'h04, 32'h77CF);
		apb(1'b1, 8'h14, 32'hFFFF40FF);
		rdc("window reserved", 8'h14, 32'h40FF);
		cfg_m[1] = 32'h77CF;
		win_m[1] = 16'h40FF;
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 1, er);
		apb(1'b1, 8'h05, 32'h0);
		chk("unaligned error", 1, er);
		rdc("unaligned write ignored", 8'h04, 32'h77CF);
		$display("test reserved bits done");
		for (i = 0; i < 21; i++) begin
			seed = lfsr(seed);
			c = seed & 32'h77CF;
			c[0] = i[0];
			c[2:1] = i[2:1];
			if (c[7:6] == 2'b10 && c[2:1] == 2'b10) c[2:1] = 2'b01;
			if (c[2:1] == 2'b11) c[7:6] = 2'b00;
			apb(1'b1, 8'(4 * (i % 4)), c);
			cfg_m[i%4] = c;
			acc(seed[8], {hi[i%7], seed[31:8]}, seed[12:9]);
		end
		rdc("status after miss", 8'h20, 32'h1001);
		$display("test random accesses done");
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc("window after reset", 8'h14, 32'h14FC);
		rdc("cfg after reset", 8'h04, 32'h7700);
		win_m[1] = 16'h14FC;
		for (i = 0; i < 4; i++) cfg_m[i] = 32'h7700;
		acc(1'b0, 32'h14000010, 4'h3);
		$display("test reset restore done");
		close_out();
	end
endmodule
`default_nettype wire
